// ==== design/can_cfg_defines.svh ====
`ifndef CAN_CFG_DEFINES_SVH
`define CAN_CFG_DEFINES_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define ADDR_BAUD_PRESCALER 16'hffb8
`define ADDR_RX_BUFFER_COUNT 16'hffbc

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_BAUD_PRESCALER 8'h3f
`define RST_RX_BUFFER_COUNT 8'hc0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CNT_FIELD_MSB 4
`define CNT_FIELD_LSB 0
`define CNT_TOP_BIT 4
`define FORCE_RESET_BIT 5
`define RAM_WIN_MSB 7
`define RAM_WIN_LSB 6
`define CLK_SRC_MSB 7
`define CLK_SRC_LSB 6
`define PRESC_MSB 5
`define PRESC_LSB 0

// ----------------------------------------------------------------
// Encodings and counts
// ----------------------------------------------------------------
`define CNT_SIXTEEN 5'h10
`define RAM_WIN_ONLY 2'h3
`define BUS_IDLE_BITS 11'h580
`define INIT_DELAY_BITS 4'hb

`endif

// ==== design/can_cfg_pkg.sv ====
`default_nettype none
package can_cfg_pkg;

  typedef enum logic [1:0] {
    SRC_MAIN,
    SRC_DIV2,
    SRC_DIV4,
    SRC_ALT
  } clk_src_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cpu_req_t;

  typedef struct packed {
    logic initRequest;
    logic resolutionMode;
    logic [1:0] prescalerHigh;
  } ctrl_in_t;

endpackage

`default_nettype wire

// ==== design/can_buffer_count_and_prescaler.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "can_cfg_defines.svh"

module can_buffer_count_and_prescaler (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // CPU register access
  input wire can_cfg_pkg::cpu_req_t cpuReq,
  output logic [7:0] rdata_reg,
  // Neighbouring control registers
  input wire can_cfg_pkg::ctrl_in_t ctrlIn,
  // Protocol machine
  input wire logic busOffSet,
  input wire logic bitTick,
  input wire logic recessiveBit,
  output logic busOff_reg,
  output logic initConfirmed_reg,
  output logic protocolReset_reg,
  output logic forceInitRequest_reg,
  // Clocking input and outputs
  input wire logic alternateCanClock,
  output logic moduleTick_reg,
  output logic tqTick_reg,
  // Configuration outputs
  output logic [4:0] bufferCount_reg,
  output logic [1:0] ramWindow_reg
);
  import can_cfg_pkg::*;

  // Reset image of the count register; its fields are cut out below so
  // that both come from one constant.
  localparam logic [7:0] countResetImage = `RST_RX_BUFFER_COUNT;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] prescaler_reg, prescaler_next;
  logic [4:0] bufferCount_next;
  logic [1:0] ramWindow_next;
  logic [7:0] rdata_next;
  logic [7:0] countReadback;
  logic wrCount, wrPresc, forceReset;

  assign countReadback = {ramWindow_reg, 1'b0, bufferCount_reg};

  always_comb begin
    wrCount = cpuReq.wr && (cpuReq.addr == `ADDR_RX_BUFFER_COUNT);
    wrPresc = cpuReq.wr && (cpuReq.addr == `ADDR_BAUD_PRESCALER);
    // forced reset only acts while bus-off
    forceReset = wrCount && cpuReq.wdata[`FORCE_RESET_BIT] && busOff_reg;
    bufferCount_next = bufferCount_reg;
    ramWindow_next = ramWindow_reg;
    prescaler_next = prescaler_reg;
    // writes outside confirmed init are dropped
    if (wrCount && initConfirmed_reg) begin
      // count field taken from low five bits
      // A zero count is prohibited yet stored as written; keeping clear
      // of it is left to software.
      bufferCount_next = cpuReq.wdata[`CNT_FIELD_MSB:`CNT_FIELD_LSB];
      if (cpuReq.wdata[`CNT_TOP_BIT] &&
          (cpuReq.wdata[`CNT_TOP_BIT-1:`CNT_FIELD_LSB] != 4'h0)) begin
        bufferCount_next = `CNT_SIXTEEN;
      end
      // only the single legal window code is stored
      // Any other code is prohibited and leaves the window unchanged.
      if (cpuReq.wdata[`RAM_WIN_MSB:`RAM_WIN_LSB] == `RAM_WIN_ONLY) begin
        ramWindow_next = `RAM_WIN_ONLY;
      end
    end
    // prescaler accepted only once init is confirmed
    // A write that lands while the quantum counter runs would change the
    // bit length mid-frame, so outside confirmed init it is dropped, not held.
    if (wrPresc && initConfirmed_reg) begin
      prescaler_next = cpuReq.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      bufferCount_reg <= countResetImage[`CNT_FIELD_MSB:`CNT_FIELD_LSB];
      ramWindow_reg <= countResetImage[`RAM_WIN_MSB:`RAM_WIN_LSB];
      prescaler_reg <= `RST_BAUD_PRESCALER;
    end else begin
      bufferCount_reg <= bufferCount_next;
      ramWindow_reg <= ramWindow_next;
      prescaler_reg <= prescaler_next;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // The read word is held until the next read, so software may fetch
  // it at leisure; an unmapped address answers with zero.
  always_comb begin
    rdata_next = rdata_reg;
    if (cpuReq.rd) begin
      case (cpuReq.addr)
        `ADDR_RX_BUFFER_COUNT: rdata_next = countReadback;
        `ADDR_BAUD_PRESCALER: rdata_next = prescaler_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Bus-off and init confirmation
  // ----------------------------------------------------------------
  logic busOff_next, initConfirmed_next;
  logic protocolReset_next, forceInitRequest_next;
  // Eleven bits hold the full run of recessive bits needed to recover.
  logic [10:0] idleCnt_reg, idleCnt_next;
  logic [3:0] initCnt_reg, initCnt_next;

  always_comb begin
    busOff_next = busOff_reg;
    idleCnt_next = idleCnt_reg;
    initConfirmed_next = initConfirmed_reg;
    initCnt_next = initCnt_reg;
    protocolReset_next = 1'b0;
    forceInitRequest_next = 1'b0;
    if (busOff_reg && bitTick) begin
      // recovery needs an unbroken run of recessive bits
      if (!recessiveBit) begin
        idleCnt_next = 11'h000;
      end else if (idleCnt_reg == `BUS_IDLE_BITS - 11'h001) begin
        busOff_next = 1'b0;
        idleCnt_next = 11'h000;
      end else begin
        idleCnt_next = idleCnt_reg + 11'h001;
      end
    end
    if (!ctrlIn.initRequest) begin
      initConfirmed_next = 1'b0;
      initCnt_next = 4'h0;
    end else if (!busOff_reg && !initConfirmed_reg && bitTick) begin
      // confirmation lags the request by some bit times
      // The count holds its place across bus-off and restarts only when
      // the request is withdrawn.
      if (initCnt_reg == `INIT_DELAY_BITS - 4'h1) begin
        initConfirmed_next = 1'b1;
      end else begin
        initCnt_next = initCnt_reg + 4'h1;
      end
    end
    // A new bus-off beats an idle run that ends in the same cycle.
    if (busOffSet) begin
      busOff_next = 1'b1;
      idleCnt_next = 11'h000;
    end
    // forced reset leaves bus-off straight into init
    // It comes last so that it also overrides a bus-off raised with it.
    if (forceReset) begin
      busOff_next = 1'b0;
      idleCnt_next = 11'h000;
      protocolReset_next = 1'b1;
      forceInitRequest_next = 1'b1;
      initConfirmed_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      busOff_reg <= 1'b0;
      idleCnt_reg <= 11'h000;
      initConfirmed_reg <= 1'b0;
      initCnt_reg <= 4'h0;
      protocolReset_reg <= 1'b0;
      forceInitRequest_reg <= 1'b0;
    end else begin
      busOff_reg <= busOff_next;
      idleCnt_reg <= idleCnt_next;
      initConfirmed_reg <= initConfirmed_next;
      initCnt_reg <= initCnt_next;
      protocolReset_reg <= protocolReset_next;
      forceInitRequest_reg <= forceInitRequest_next;
    end
  end

  // ----------------------------------------------------------------
  // Module clock source
  // ----------------------------------------------------------------
  // The alternate clock is only sampled, so it must run well below
  // half the system clock rate to be seen edge by edge.
  logic altSync1_reg, altSync2_reg, altPrev_reg;
  logic [1:0] div_reg, div_next;
  logic moduleTick_next;
  clk_src_t clkSrc;

  // The divider runs freely, so a new source code takes effect within
  // four cycles and no partial module tick is ever produced.
  assign clkSrc = clk_src_t'(prescaler_reg[`CLK_SRC_MSB:`CLK_SRC_LSB]);

  always_comb begin
    div_next = div_reg + 2'h1;
    // Every source code is legal, so the default branch is never reached.
    // source field selects the module clock enable
    case (clkSrc)
      SRC_MAIN: moduleTick_next = 1'b1;
      SRC_DIV2: moduleTick_next = div_reg[0];
      SRC_DIV4: moduleTick_next = (div_reg == 2'h3);
      SRC_ALT: moduleTick_next = altSync2_reg && !altPrev_reg;
      default: moduleTick_next = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      altSync1_reg <= 1'b0;
      altSync2_reg <= 1'b0;
      altPrev_reg <= 1'b0;
      div_reg <= 2'h0;
      moduleTick_reg <= 1'b0;
    end else begin
      altSync1_reg <= alternateCanClock;
      altSync2_reg <= altSync1_reg;
      altPrev_reg <= altSync2_reg;
      div_reg <= div_next;
      moduleTick_reg <= moduleTick_next;
    end
  end

  // ----------------------------------------------------------------
  // Time quantum prescaler
  // ----------------------------------------------------------------
  logic [7:0] tqCnt_reg, tqCnt_next;
  // Eight bits cover the longest quantum of either resolution.
  logic [7:0] tqLast;
  logic tqTick_next;

  always_comb begin
    if (ctrlIn.resolutionMode) begin
      // eight-bit value, clocks per quantum is value plus one
      tqLast = {ctrlIn.prescalerHigh, prescaler_reg[`PRESC_MSB:`PRESC_LSB]};
    end else begin
      // clocks per quantum is twice value plus two
      tqLast = {1'b0, prescaler_reg[`PRESC_MSB:`PRESC_LSB], 1'b1};
    end
    tqCnt_next = tqCnt_reg;
    tqTick_next = 1'b0;
    // quantum counting advances only on module clock ticks
    // A slow source thus stretches every quantum by the same factor.
    if (moduleTick_reg) begin
      // Comparing with >= lets a count left above a newly shortened
      // limit wrap at once instead of running the long way round.
      if (tqCnt_reg >= tqLast) begin
        tqCnt_next = 8'h00;
        tqTick_next = 1'b1;
      end else begin
        tqCnt_next = tqCnt_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tqCnt_reg <= 8'h00;
      tqTick_reg <= 1'b0;
    end else begin
      tqCnt_reg <= tqCnt_next;
      tqTick_reg <= tqTick_next;
    end
  end

endmodule

`default_nettype wire

// ==== sim/can_bus_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module can_bus_model (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Bus conditions set by the bench
  input wire logic dominant,
  input wire logic errorBurst,
  // Toward the controller
  output logic bitTick,
  output logic recessiveBit,
  output logic busOffSet
);
  // ----
  // Bit timing
  // ----
  logic [1:0] phase_reg;
  always_ff @(posedge clk) begin
    phase_reg <= srst ? 2'h0 : phase_reg + 2'h1;
    bitTick <= !srst && phase_reg == 2'h3;
    busOffSet <= !srst && errorBurst && phase_reg == 2'h3;
  end
  // The transceiver pulls an undriven bus to recessive, so idle reads high.
  assign recessiveBit = !dominant;
endmodule
`default_nettype wire

// ==== sim/can_cfg_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "can_cfg_defines.svh"
module can_cfg_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Watched ports
  input wire can_cfg_pkg::cpu_req_t cpuReq,
  input wire can_cfg_pkg::ctrl_in_t ctrlIn,
  input wire logic [7:0] rdata_reg,
  input wire logic busOff_reg,
  input wire logic initConfirmed_reg,
  input wire logic protocolReset_reg,
  input wire logic forceInitRequest_reg,
  input wire logic [4:0] bufferCount_reg,
  input wire logic moduleTick_reg,
  input wire logic tqTick_reg,
  input wire logic [1:0] ramWindow_reg
);
  import can_cfg_pkg::*;
  // ----
  // Checks
  // ----
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);
  logic cntWr;
  logic [7:0] wd;
  assign cntWr = cpuReq.wr && cpuReq.addr == `ADDR_RX_BUFFER_COUNT;
  assign wd = cpuReq.wdata;
  sequence forceReq;
    cntWr && wd[5] && busOff_reg;
  endsequence
  sequence initEntered;
    protocolReset_reg && forceInitRequest_reg && initConfirmed_reg
      && !busOff_reg ##1 !protocolReset_reg;
  endsequence
  force_entry_a: assert property (forceReq |=> initEntered)
    else $error("forced reset failed");
  force_ignore_a: assert property (
    cntWr && !busOff_reg |=> !protocolReset_reg)
    else $error("stray protocol reset");
  count_load_a: assert property (
    cntWr && initConfirmed_reg && !wd[4] |=> bufferCount_reg == 5'($past(wd)))
    else $error("count not loaded");
  count_top_a: assert property (
    cntWr && initConfirmed_reg && wd[4] |=> bufferCount_reg == 5'h10)
    else $error("count not sixteen");
  count_gate_a: assert property (
    cntWr && !initConfirmed_reg |=> $stable(bufferCount_reg))
    else $error("count changed outside init");
  window_fixed_a: assert property (ramWindow_reg == 2'h3)
    else $error("window code changed");
  count_read_a: assert property (
    cpuReq.rd && cpuReq.addr == `ADDR_RX_BUFFER_COUNT |=>
      rdata_reg == {$past(ramWindow_reg), 1'b0, $past(bufferCount_reg)})
    else $error("count read wrong");
  busoff_block_a: assert property (
    busOff_reg && !initConfirmed_reg && !cntWr |=> !initConfirmed_reg)
    else $error("init confirmed in bus-off");
  init_drop_a: assert property (
    !ctrlIn.initRequest && !cntWr |=> !initConfirmed_reg)
    else $error("init confirm held");
  quantum_paced_a: assert property (
    tqTick_reg |-> $past(moduleTick_reg))
    else $error("quantum tick without module tick");
endmodule
bind can_buffer_count_and_prescaler can_cfg_checker chk_u (.clk, .srst,
  .cpuReq, .ctrlIn, .rdata_reg, .busOff_reg, .initConfirmed_reg,
  .protocolReset_reg, .forceInitRequest_reg, .bufferCount_reg,
  .moduleTick_reg, .tqTick_reg, .ramWindow_reg);
`default_nettype wire

// ==== sim/can_buffer_count_and_prescaler_test.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "can_cfg_defines.svh"
module can_buffer_count_and_prescaler_test;
  import can_cfg_pkg::*;
  // ----
  // Harness
  // ----
  logic clk = 0, srst = 1, alternateCanClock = 0, dominant = 0;
  logic errorBurst = 0, bitTick, recessiveBit, busOffSet, busOff_reg;
  logic initConfirmed_reg, protocolReset_reg, forceInitRequest_reg;
  logic tqTick_reg, moduleTick_reg;
  logic [7:0] rdata_reg;
  logic [4:0] bufferCount_reg;
  logic [1:0] ramWindow_reg;
  cpu_req_t cpuReq = '0;
  ctrl_in_t ctrlIn = '0;
  int mismatches = 0, comparisons = 0;
  can_buffer_count_and_prescaler dut_u (.clk, .srst, .cpuReq, .rdata_reg,
    .ctrlIn, .busOffSet, .bitTick, .recessiveBit, .busOff_reg,
    .initConfirmed_reg, .protocolReset_reg, .forceInitRequest_reg,
    .alternateCanClock, .moduleTick_reg, .tqTick_reg, .bufferCount_reg,
    .ramWindow_reg);
  can_bus_model bus_u (.clk, .srst, .dominant, .errorBurst, .bitTick,
    .recessiveBit, .busOffSet);
  initial begin
    forever #10 clk = ~clk;
  end
  // Seven clock periods, offset so that no toggle meets a clock edge.
  initial begin
    #5;
    forever #70 alternateCanClock = ~alternateCanClock;
  end
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      mismatches++;
      print_verdict();
    end
  endtask
  task automatic acc(input logic [15:0] a, input logic [7:0] d, input logic w);
    step();
    cpuReq = '{a, d, w, !w};
    step();
    cpuReq = '0;
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] e);
    acc(a, 8'h00, 1'b0);
    chk(rdata_reg, e);
  endtask
  task automatic goBusOff();
    int n;
    errorBurst = 1;
    for (n = 0; n < 20 && !busOff_reg; n++) step();
    errorBurst = 0;
    bound(n, 20);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_reset();
    rchk(`ADDR_RX_BUFFER_COUNT, 8'hc0);
    rchk(`ADDR_BAUD_PRESCALER, 8'h3f);
    rchk(16'hffb0, 8'h00);
    chk(moduleTick_reg, 1'b1);
    acc(`ADDR_RX_BUFFER_COUNT, 8'h05, 1'b1);
    acc(`ADDR_BAUD_PRESCALER, 8'h00, 1'b1);
    rchk(`ADDR_RX_BUFFER_COUNT, 8'hc0);
    rchk(`ADDR_BAUD_PRESCALER, 8'h3f);
    $display("reset test done");
  endtask
  task automatic t_busoff();
    goBusOff();
    ctrlIn.initRequest = 1;
    dominant = 1;
    repeat (60) step();
    chk(initConfirmed_reg, 1'b0);
    dominant = 0;
    acc(`ADDR_RX_BUFFER_COUNT, 8'h20, 1'b1);
    chk({busOff_reg, initConfirmed_reg, protocolReset_reg}, 3'h3);
    chk(forceInitRequest_reg, 1'b1);
    $display("bus-off test done");
  endtask
  task automatic t_count();
    logic [7:0] w[7] = '{8'h01, 8'h10, 8'h1f, 8'h18, 8'h45, 8'h0f, 8'h2b};
    logic [7:0] e[7] = '{8'hc1, 8'hd0, 8'hd0, 8'hd0, 8'hc5, 8'hcf, 8'hcb};
    foreach (w[i]) begin
      acc(`ADDR_RX_BUFFER_COUNT, w[i], 1'b1);
      rchk(`ADDR_RX_BUFFER_COUNT, e[i]);
      chk(bufferCount_reg, e[i][4:0]);
    end
    $display("count test done");
  endtask
  task automatic period(input int e);
    int n, k;
    for (k = 0; k < 3; k++) begin
      for (n = 1; n < 300; n++) begin
        step();
        if (tqTick_reg === 1'b1) break;
      end
      bound(n, 300);
    end
    chk(n, e);
  endtask
  task automatic t_presc();
    logic [7:0] w[7] = '{8'h02, 8'h41, 8'h80, 8'hc0, 8'h02, 8'h00, 8'h00};
    logic [2:0] m[7] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h4, 3'h5, 3'h4};
    int e[7] = '{6, 8, 8, 14, 3, 65, 1};
    foreach (w[i]) begin
      ctrlIn[2:0] = m[i];
      acc(`ADDR_BAUD_PRESCALER, w[i], 1'b1);
      rchk(`ADDR_BAUD_PRESCALER, w[i]);
      period(e[i]);
    end
    $display("prescaler test done");
  endtask
  task automatic t_idle();
    int n, c;
    goBusOff();
    n = 0;
    for (c = 0; c < 8000 && busOff_reg; c++) begin
      step();
      n += bitTick;
    end
    bound(c, 8000);
    chk(n, `BUS_IDLE_BITS);
    $display("idle test done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1;
    srst = 0;
    t_reset();
    t_busoff();
    t_count();
    t_presc();
    t_idle();
    print_verdict();
  end
endmodule
`default_nettype wire
